// ### include/cil_if.sv
`timescale 1ns/10ps
interface cil_if;
    logic [15:0] device_identifier_in;
    logic [15:0] vendor_identifier_in;
    logic [7:0]  revision_identifier_in;
    logic [15:0] subsystem_identifier_in;
    logic [15:0] subsystem_vendor_identifier_in;
    logic [63:0] serial_number_in;
    logic [4:0]  interrupt_message_number_in;
    logic        common_clock_override;
    logic        extended_sync_override;
    logic [2:0]  forced_payload_size;
    logic [2:0]  link_power_state_code;
    logic [6:0]  traffic_class_map_out;
    logic        ecrc_check_enable_out;
    logic        ecrc_generate_enable_out;

    modport device (
        input  device_identifier_in, vendor_identifier_in,
        input  revision_identifier_in, subsystem_identifier_in,
        input  subsystem_vendor_identifier_in, serial_number_in,
        input  interrupt_message_number_in, common_clock_override,
        input  extended_sync_override, forced_payload_size,
        output link_power_state_code, traffic_class_map_out,
        output ecrc_check_enable_out, ecrc_generate_enable_out
    );
    modport user (
        output device_identifier_in, vendor_identifier_in,
        output revision_identifier_in, subsystem_identifier_in,
        output subsystem_vendor_identifier_in, serial_number_in,
        output interrupt_message_number_in, common_clock_override,
        output extended_sync_override, forced_payload_size,
        input  link_power_state_code, traffic_class_map_out,
        input  ecrc_check_enable_out, ecrc_generate_enable_out
    );
endinterface // cil_if

// ### include/cil_pkg.sv
//------------------------------------------------------------
// Functional notes
//------------------------------------------------------------
package cil_pkg;
    //--------------------------------------------------------
    // configuration space byte addresses
    //--------------------------------------------------------
    localparam logic [11:0] CFG_ID_ADDR        = 12'h000;
    localparam logic [11:0] CFG_REV_ADDR       = 12'h008;
    localparam logic [11:0] CFG_SUBSYS_ADDR    = 12'h02c;
    localparam logic [11:0] CFG_PCIE_CAP_ADDR  = 12'h060;
    localparam logic [11:0] CFG_DEV_CTRL_ADDR  = 12'h068;
    localparam logic [11:0] CFG_LINK_CTRL_ADDR = 12'h070;
    localparam logic [11:0] CFG_DSN_ADDR       = 12'h100;
    localparam logic [11:0] DSN_LOW_OFS        = 12'h004;
    localparam logic [11:0] DSN_HIGH_OFS       = 12'h008;
    localparam logic [11:0] CFG_DSN_LOW_ADDR   = CFG_DSN_ADDR + DSN_LOW_OFS;
    localparam logic [11:0] CFG_DSN_HIGH_ADDR  = CFG_DSN_ADDR + DSN_HIGH_OFS;
    localparam logic [11:0] CFG_VC_CAP_ADDR    = 12'h140;
    localparam logic [11:0] VC_RES_CTRL_OFS    = 12'h014;
    localparam logic [11:0] CFG_VC_RES_ADDR    = CFG_VC_CAP_ADDR
                                                 + VC_RES_CTRL_OFS;
    //--------------------------------------------------------
    // fields and reset values
    //--------------------------------------------------------
    localparam logic [7:0]  PCIE_CAP_ID      = 8'h10;
    localparam logic [3:0]  PCIE_CAP_VER     = 4'h2;
    localparam logic [15:0] DSN_CAP_ID       = 16'h0003;
    localparam logic [15:0] VC_CAP_ID        = 16'h0002;
    localparam int unsigned LINK_CTRL_CC_BIT = 6;
    localparam int unsigned LINK_CTRL_ES_BIT = 7;
    localparam int unsigned MSGNUM_LSB       = 25;
    localparam int unsigned MPS_LSB          = 5;
    localparam logic [15:0] DEV_CTRL_RESET   = 16'h0000;
    localparam logic [15:0] LINK_CTRL_RESET  = 16'h0000;
    localparam logic [6:0]  TC_MAP_RESET     = 7'h7f;
    localparam logic [2:0]  MPS_MAX_CODE     = 3'h5;
    localparam logic [10:0] MPS_BASE_DW      = 11'h020;
    //--------------------------------------------------------
    // link power state codes
    //--------------------------------------------------------
    localparam logic [2:0] LS_L0       = 3'h0;
    localparam logic [2:0] LS_SW_L1    = 3'h1;
    localparam logic [2:0] LS_SW_L23   = 3'h2;
    localparam logic [2:0] LS_PME      = 3'h3;
    localparam logic [2:0] LS_ASPM_L0S = 3'h4;
    localparam logic [2:0] LS_TR_L1    = 3'h5;
    localparam logic [2:0] LS_TR_L23   = 3'h6;
    localparam logic [2:0] LS_ASPM_L1  = 3'h7;
    //--------------------------------------------------------
    // controller register map, byte offsets
    //--------------------------------------------------------
    localparam logic [7:0] WB_IDS_ADDR    = 8'h00;
    localparam logic [7:0] WB_SUBSYS_ADDR = 8'h04;
    localparam logic [7:0] WB_MISC_ADDR   = 8'h08;
    localparam logic [7:0] WB_SN_LO_ADDR  = 8'h0c;
    localparam logic [7:0] WB_SN_HI_ADDR  = 8'h10;
    localparam logic [7:0] WB_STAT_ADDR   = 8'h14;
    localparam int unsigned MISC_MSG_LSB  = 8;
    localparam int unsigned MISC_CC_BIT   = 16;
    localparam int unsigned MISC_ES_BIT   = 17;
    localparam int unsigned MISC_MPS_LSB  = 20;
    localparam int unsigned STAT_MAP_LSB  = 8;
    localparam int unsigned STAT_CHK_BIT  = 16;
    localparam int unsigned STAT_GEN_BIT  = 17;
    // identity reset values are arbitrary
    localparam logic [31:0] IDS_RESET    = 32'h0001_0001;
    localparam logic [31:0] SUBSYS_RESET = 32'h0001_0001;
    localparam logic [31:0] MISC_RESET   = 32'h0000_0001;
    localparam logic [31:0] SN_RESET     = 32'h0000_0000;
endpackage

// ### sim/cil_asserts.sv
`timescale 1ns/10ps
module cil_asserts (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // link outputs
    input  wire logic [2:0]  link_power_state_code,
    input  wire logic [6:0]  traffic_class_map_out,
    input  wire logic        ecrc_check_enable_out,
    input  wire logic        ecrc_generate_enable_out,
    // config writes and power inputs
    input  wire logic        cfg_wr_en_i,
    input  wire logic [11:0] cfg_wr_addr_i,
    input  wire logic [31:0] cfg_wr_data_i,
    input  wire logic        pm_aspm_l0s_i,
    input  wire logic        pm_aspm_l1_i,
    input  wire logic        pm_sw_l1_i,
    input  wire logic        pm_sw_l23_i,
    input  wire logic        pm_pme_i,
    input  wire logic        pm_moving_i
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [5:0] pm;
    logic [6:0] wr_map;
    assign pm = {pm_aspm_l0s_i, pm_aspm_l1_i, pm_sw_l1_i, pm_sw_l23_i,
                 pm_pme_i, pm_moving_i};
    // register bit 0 is fixed, so only 7:1 reach the map
    assign wr_map = cfg_wr_data_i[7:1];
    map_reset_a: assert property (disable iff (1'b0)
        rst_i |=> traffic_class_map_out == 7'h7f) else $error("map reset");
    code_reset_a: assert property (disable iff (1'b0)
        rst_i |=> link_power_state_code == 3'h0) else $error("code reset");
    ecrc_zero_a: assert property (!ecrc_check_enable_out &&
        !ecrc_generate_enable_out) else $error("ecrc enable set");
    map_write_a: assert property (cfg_wr_en_i &&
        cfg_wr_addr_i == 12'h154 |-> ##2 traffic_class_map_out ==
        $past(wr_map, 2)) else $error("map not shifted write");
    map_cause_a: assert property ($changed(traffic_class_map_out)
        |-> $past(cfg_wr_en_i, 2)) else $error("map changed unasked");
    l0s_code_a: assert property (pm_aspm_l0s_i |=>
        link_power_state_code == 3'h4) else $error("l0s code");
    aspm_l1_a: assert property (pm == 6'h10 |=>
        link_power_state_code == 3'h7) else $error("aspm l1 code");
    move_l1_a: assert property (pm == 6'h09 |=>
        link_power_state_code == 3'h5) else $error("moving l1 code");
    idle_l0_a: assert property (pm == 6'h00 |=>
        link_power_state_code == 3'h0) else $error("l0 code");
    sw_l1_a: assert property (pm == 6'h08 |=>
        link_power_state_code == 3'h1) else $error("sw l1 code");
endmodule // cil_asserts

// ### sim/cil_tb_top.sv
`timescale 1ns/10ps
module cil_tb_top;
    import cil_pkg::*;
    //------------------------------------------------------------
    // stimulus and wiring
    //------------------------------------------------------------
    logic        clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, ack;
    logic        rd_en = 0, rd_v, wr_en = 0, rv = 0, rerr, ecc, ees;
    logic [7:0]  adr = '0;
    logic [31:0] wdat = '0, wbd, wbr, rd_d, wr_d = '0, d;
    logic [11:0] rd_a = '0, wr_a = '0;
    logic [5:0]  pm = '0;
    logic [9:0]  rl = '0;
    logic [2:0]  emps;
    int          fail_count = 0, num_checks = 0, cycles = 0;
    localparam logic [5:0] PMV [8] = '{6'h00, 6'h08, 6'h04, 6'h02,
                                       6'h20, 6'h09, 6'h05, 6'h10};
    cil_if lk ();
    cil_user cil_user_i (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
        .wb_dat_i(wdat), .wb_dat_o(wbd), .wb_ack_o(ack), .link(lk.user));
    cil_device #(.MPS_FORCE_ATTR(1)) cil_device_i (.clk_i(clk), .rst_i(rst),
        .link(lk.device), .cfg_rd_en_i(rd_en), .cfg_rd_addr_i(rd_a),
        .cfg_rd_data_o(rd_d), .cfg_rd_valid_o(rd_v), .cfg_wr_en_i(wr_en),
        .cfg_wr_addr_i(wr_a), .cfg_wr_data_i(wr_d), .pm_aspm_l0s_i(pm[5]),
        .pm_aspm_l1_i(pm[4]), .pm_sw_l1_i(pm[3]), .pm_sw_l23_i(pm[2]),
        .pm_pme_i(pm[1]), .pm_moving_i(pm[0]), .rx_len_valid_i(rv),
        .rx_len_i(rl), .rx_len_err_o(rerr), .eff_common_clock_o(ecc),
        .eff_ext_sync_o(ees), .eff_mps_o(emps));
    cil_asserts cil_asserts_i (.clk_i(clk), .rst_i(rst),
        .link_power_state_code(lk.link_power_state_code),
        .traffic_class_map_out(lk.traffic_class_map_out),
        .ecrc_check_enable_out(lk.ecrc_check_enable_out),
        .ecrc_generate_enable_out(lk.ecrc_generate_enable_out),
        .cfg_wr_en_i(wr_en), .cfg_wr_addr_i(wr_a), .cfg_wr_data_i(wr_d),
        .pm_aspm_l0s_i(pm[5]), .pm_aspm_l1_i(pm[4]), .pm_sw_l1_i(pm[3]),
        .pm_sw_l23_i(pm[2]), .pm_pme_i(pm[1]), .pm_moving_i(pm[0]));
    always #4 clk = ~clk;
    //------------------------------------------------------------
    // shared tasks
    //------------------------------------------------------------
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task wb(input logic w, input logic [7:0] a, input logic [31:0] v);
        int n;
        n = 0;
        cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= v;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        wbr = wbd;
        chk("wb ack", ack, 1);
        cyc <= 0; stb <= 0; we <= 0;
        @(posedge clk);
    endtask
    task cfg_rd(input logic [11:0] a);
        rd_en <= 1; rd_a <= a;
        @(posedge clk);
        rd_en <= 0;
        @(posedge clk);
        chk("cfg valid", rd_v, 1);
        d = rd_d;
    endtask
    task cfg_wr(input logic [11:0] a, input logic [31:0] v);
        wr_en <= 1; wr_a <= a; wr_d <= v;
        @(posedge clk);
        wr_en <= 0;
        @(posedge clk);
    endtask
    task rx(input logic [9:0] n, input logic e);
        rv <= 1; rl <= n;
        @(posedge clk);
        rv <= 0;
        @(posedge clk);
        chk("rx length error", rerr, e);
    endtask
    //------------------------------------------------------------
    // scenarios
    //------------------------------------------------------------
    task t_reset;
        cfg_rd(12'h000); chk("id reset", d, IDS_RESET);
        wb(0, 8'h08, 0); chk("misc reset", wbr, MISC_RESET);
        wb(1, 8'h14, 0); wb(0, 8'h14, 0);
        chk("stat map", wbr[14:8], 7'h7f);
        wb(0, 8'h18, 0); chk("unmapped", wbr, 0);
        $display("reset test done");
    endtask
    task t_ident;
        wb(1, 8'h00, 32'h1234abcd); wb(1, 8'h04, 32'h5678c0de);
        wb(1, 8'h08, 32'h0033135a); wb(1, 8'h0c, 32'h89abcdef);
        wb(1, 8'h10, 32'h01234567);
        cfg_rd(12'h000); chk("dev ven id", d, 32'h1234abcd);
        cfg_rd(12'h008); chk("revision", d, 32'h5a);
        cfg_rd(12'h02c); chk("subsystem", d, 32'h5678c0de);
        cfg_rd(12'h104); chk("serial low", d, 32'h89abcdef);
        cfg_rd(12'h108); chk("serial high", d, 32'h01234567);
        cfg_rd(12'h060); chk("msg number", d[29:25], 5'h13);
        $display("identity test done");
    endtask
    task t_over;
        cfg_wr(12'h068, 0);
        repeat (3) @(posedge clk);
        chk("eff common clock", ecc, 1);
        chk("eff ext sync", ees, 1);
        chk("eff payload", emps, 3);
        cfg_rd(12'h070); chk("link ctrl", d, 0);
        cfg_rd(12'h068); chk("dev ctrl", d, 0);
        rx(10'd257, 1); rx(10'd256, 0);
        wb(1, 8'h08, 32'h5a);
        repeat (3) @(posedge clk);
        chk("override off", {ecc, ees}, 0);
        // forced size 0 must win over a large device control field
        cfg_wr(12'h068, 32'h00a0); cfg_wr(12'h070, 32'h00c0);
        repeat (2) @(posedge clk);
        chk("forced payload kept", emps, 0);
        chk("link ctrl effect", {ecc, ees}, 3);
        cfg_rd(12'h068); chk("dev ctrl kept", d, 32'ha0);
        rx(10'd33, 1);
        $display("override test done");
    endtask
    task t_link;
        for (int i = 0; i < 8; i++) begin
            pm <= PMV[i];
            repeat (2) @(posedge clk);
            chk("link code", lk.link_power_state_code, 32'(i));
        end
        pm <= 0;
        $display("link state test done");
    endtask
    task t_map;
        // bit 0 set too: it must be dropped, not shifted in
        cfg_wr(12'h154, 32'ha5);
        @(posedge clk);
        chk("map", lk.traffic_class_map_out, 7'h52);
        cfg_wr(12'h154, 32'h02);
        @(posedge clk);
        chk("map bit0", lk.traffic_class_map_out, 7'h01);
        $display("map test done");
    endtask
    task close_out;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            close_out();
        end
    end
    initial begin
        repeat (6) @(posedge clk);
        rst <= 0;
        @(posedge clk);
        t_reset(); t_ident(); t_over(); t_link(); t_map();
        close_out();
    end
endmodule // cil_tb_top

// ### src/cil_device.sv
// Our own choice: the Wishbone register port.
`timescale 1ns/10ps
module cil_device #(
    parameter int unsigned MPS_FORCE_ATTR = 1
) (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // user side link
    cil_if.device            link,
    // configuration access
    input  wire logic        cfg_rd_en_i,
    input  wire logic [11:0] cfg_rd_addr_i,
    output logic      [31:0] cfg_rd_data_o,
    output logic             cfg_rd_valid_o,
    input  wire logic        cfg_wr_en_i,
    input  wire logic [11:0] cfg_wr_addr_i,
    input  wire logic [31:0] cfg_wr_data_i,
    // power management status
    input  wire logic        pm_aspm_l0s_i,
    input  wire logic        pm_aspm_l1_i,
    input  wire logic        pm_sw_l1_i,
    input  wire logic        pm_sw_l23_i,
    input  wire logic        pm_pme_i,
    input  wire logic        pm_moving_i,
    // received payload check
    input  wire logic        rx_len_valid_i,
    input  wire logic [9:0]  rx_len_i,
    output logic             rx_len_err_o,
    // effective link behaviour
    output logic             eff_common_clock_o,
    output logic             eff_ext_sync_o,
    output logic      [2:0]  eff_mps_o
);
    import cil_pkg::*;

    if (MPS_FORCE_ATTR > 1) begin : g_bad_attr
        $error("MPS_FORCE_ATTR must be 0 or 1");
    end

    //--------------------------------------------------------
    // helpers
    //--------------------------------------------------------
    function automatic logic [2:0] ls_encode(
        input logic l0s, input logic a1, input logic s1,
        input logic s23, input logic pme, input logic mv);
        // aspm states win: they overlay any software state
        if (l0s) begin
            return LS_ASPM_L0S;
        end
        if (a1) begin
            return LS_ASPM_L1;
        end
        if (mv && s1) begin
            return LS_TR_L1;
        end
        if (mv && s23) begin
            return LS_TR_L23;
        end
        if (s1) begin
            return LS_SW_L1;
        end
        if (s23) begin
            return LS_SW_L23;
        end
        if (pme) begin
            return LS_PME;
        end
        return LS_L0;
    endfunction

    function automatic logic [10:0] mps_limit(input logic [2:0] m);
        logic [2:0] c;
        // reserved codes clamp to the largest size
        c = (m > MPS_MAX_CODE) ? MPS_MAX_CODE : m;
        return 11'(MPS_BASE_DW << c);
    endfunction

    //--------------------------------------------------------
    // captured identity
    //--------------------------------------------------------
    logic [15:0] dev_id_q;
    logic [15:0] ven_id_q;
    logic [7:0]  rev_id_q;
    logic [15:0] sub_id_q;
    logic [15:0] sub_ven_q;
    logic [63:0] serial_q;
    logic [4:0]  msg_num_q;
    logic        cc_ovr_q;
    logic        es_ovr_q;
    logic [2:0]  fmps_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dev_id_q  <= 16'h0000;
            ven_id_q  <= 16'h0000;
            rev_id_q  <= 8'h00;
            sub_id_q  <= 16'h0000;
            sub_ven_q <= 16'h0000;
            serial_q  <= 64'h0;
            msg_num_q <= 5'h00;
            cc_ovr_q  <= 1'b0;
            es_ovr_q  <= 1'b0;
            fmps_q    <= 3'h0;
        end else begin
            dev_id_q  <= link.device_identifier_in;
            ven_id_q  <= link.vendor_identifier_in;
            rev_id_q  <= link.revision_identifier_in;
            sub_id_q  <= link.subsystem_identifier_in;
            sub_ven_q <= link.subsystem_vendor_identifier_in;
            serial_q  <= link.serial_number_in;
            msg_num_q <= link.interrupt_message_number_in;
            cc_ovr_q  <= link.common_clock_override;
            es_ovr_q  <= link.extended_sync_override;
            fmps_q    <= link.forced_payload_size;
        end
    end

    //--------------------------------------------------------
    // software control registers
    //--------------------------------------------------------
    logic [15:0] dev_ctrl_q;
    logic [15:0] link_ctrl_q;
    logic [6:0]  tc_map_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dev_ctrl_q  <= DEV_CTRL_RESET;
            link_ctrl_q <= LINK_CTRL_RESET;
            tc_map_q    <= TC_MAP_RESET;
        end else if (cfg_wr_en_i) begin
            case ({cfg_wr_addr_i[11:2], 2'b00})
                CFG_DEV_CTRL_ADDR: begin
                    dev_ctrl_q <= cfg_wr_data_i[15:0];
                end
                CFG_LINK_CTRL_ADDR: begin
                    link_ctrl_q <= cfg_wr_data_i[15:0];
                end
                CFG_VC_RES_ADDR: begin
                    tc_map_q <= cfg_wr_data_i[7:1];
                end
                default: begin
                end
            endcase
        end
    end

    //--------------------------------------------------------
    // configuration read port
    //--------------------------------------------------------
    logic [31:0] rd_data_q;
    logic        rd_valid_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rd_data_q  <= 32'h0;
            rd_valid_q <= 1'b0;
        end else begin
            rd_valid_q <= cfg_rd_en_i;
            if (cfg_rd_en_i) begin
                case ({cfg_rd_addr_i[11:2], 2'b00})
                    CFG_ID_ADDR: begin
                        rd_data_q <= {dev_id_q, ven_id_q};
                    end
                    CFG_REV_ADDR: begin
                        rd_data_q <= {24'h0, rev_id_q};
                    end
                    CFG_SUBSYS_ADDR: begin
                        rd_data_q <= {sub_id_q, sub_ven_q};
                    end
                    CFG_PCIE_CAP_ADDR: begin
                        rd_data_q <= {2'b00, msg_num_q,
                                      5'h00, PCIE_CAP_VER,
                                      8'h00, PCIE_CAP_ID};
                    end
                    CFG_DEV_CTRL_ADDR: begin
                        // forcing never rewrites this field
                        rd_data_q <= {16'h0, dev_ctrl_q};
                    end
                    CFG_LINK_CTRL_ADDR: begin
                        // overrides leave the stored bits as written
                        rd_data_q <= {16'h0, link_ctrl_q};
                    end
                    CFG_DSN_ADDR: begin
                        rd_data_q <= {16'h0, DSN_CAP_ID};
                    end
                    CFG_DSN_LOW_ADDR: begin
                        rd_data_q <= serial_q[31:0];
                    end
                    CFG_DSN_HIGH_ADDR: begin
                        rd_data_q <= serial_q[63:32];
                    end
                    CFG_VC_CAP_ADDR: begin
                        rd_data_q <= {16'h0, VC_CAP_ID};
                    end
                    CFG_VC_RES_ADDR: begin
                        // tc0 is always mapped, vc0 always enabled
                        rd_data_q <= {1'b1, 23'h0, tc_map_q, 1'b1};
                    end
                    default: begin
                        rd_data_q <= 32'h0;
                    end
                endcase
            end
        end
    end

    assign cfg_rd_data_o  = rd_data_q;
    assign cfg_rd_valid_o = rd_valid_q;

    //--------------------------------------------------------
    // effective behaviour and payload check
    //--------------------------------------------------------
    logic       eff_cc_q;
    logic       eff_es_q;
    logic [2:0] eff_mps_q;
    logic       len_err_q;
    logic [2:0] mps_now;
    logic [10:0] rx_dw;

    assign mps_now = (MPS_FORCE_ATTR == 1) ? fmps_q
                   : dev_ctrl_q[MPS_LSB +: 3];
    // a zero length field means the largest payload
    assign rx_dw = {~|rx_len_i, rx_len_i};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            eff_cc_q  <= 1'b0;
            eff_es_q  <= 1'b0;
            eff_mps_q <= 3'h0;
            len_err_q <= 1'b0;
        end else begin
            eff_cc_q  <= link_ctrl_q[LINK_CTRL_CC_BIT] | cc_ovr_q;
            eff_es_q  <= link_ctrl_q[LINK_CTRL_ES_BIT] | es_ovr_q;
            eff_mps_q <= mps_now;
            len_err_q <= rx_len_valid_i
                         && (rx_dw > mps_limit(mps_now));
        end
    end

    assign eff_common_clock_o = eff_cc_q;
    assign eff_ext_sync_o     = eff_es_q;
    assign eff_mps_o          = eff_mps_q;
    assign rx_len_err_o       = len_err_q;

    //--------------------------------------------------------
    // status back to user logic
    //--------------------------------------------------------
    logic [2:0] ls_q;
    logic [6:0] map_out_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ls_q      <= LS_L0;
            map_out_q <= TC_MAP_RESET;
        end else begin
            ls_q      <= ls_encode(pm_aspm_l0s_i, pm_aspm_l1_i,
                                   pm_sw_l1_i, pm_sw_l23_i,
                                   pm_pme_i, pm_moving_i);
            map_out_q <= tc_map_q;
        end
    end

    assign link.link_power_state_code    = ls_q;
    assign link.traffic_class_map_out    = map_out_q;
    // ecrc is not offered, both enables stay low
    assign link.ecrc_check_enable_out    = 1'b0;
    assign link.ecrc_generate_enable_out = 1'b0;
endmodule // cil_device

// ### src/cil_user.sv
`timescale 1ns/10ps
module cil_user (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // device side link
    cil_if.user              link
);
    import cil_pkg::*;

    //--------------------------------------------------------
    // helpers
    //--------------------------------------------------------
    function automatic logic [31:0] merge(
        input logic [31:0] old, input logic [31:0] nw,
        input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    //--------------------------------------------------------
    // bus handshake
    //--------------------------------------------------------
    logic        ack_q;
    logic [31:0] dat_q;
    logic        req;
    logic        wr;

    // one access per ack; ack drops the cycle after it
    assign req = wb_cyc_i & wb_stb_i & ~ack_q;
    assign wr  = req & wb_we_i;

    //--------------------------------------------------------
    // registers
    //--------------------------------------------------------
    logic [31:0] ids_q;
    logic [31:0] sub_q;
    logic [31:0] misc_q;
    logic [31:0] sn_lo_q;
    logic [31:0] sn_hi_q;
    logic [31:0] stat_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ids_q   <= IDS_RESET;
            sub_q   <= SUBSYS_RESET;
            misc_q  <= MISC_RESET;
            sn_lo_q <= SN_RESET;
            sn_hi_q <= SN_RESET;
        end else if (wr) begin
            case (wb_adr_i)
                WB_IDS_ADDR: begin
                    ids_q <= merge(ids_q, wb_dat_i, wb_sel_i);
                end
                WB_SUBSYS_ADDR: begin
                    sub_q <= merge(sub_q, wb_dat_i, wb_sel_i);
                end
                WB_MISC_ADDR: begin
                    misc_q <= merge(misc_q, wb_dat_i, wb_sel_i);
                end
                WB_SN_LO_ADDR: begin
                    sn_lo_q <= merge(sn_lo_q, wb_dat_i, wb_sel_i);
                end
                WB_SN_HI_ADDR: begin
                    sn_hi_q <= merge(sn_hi_q, wb_dat_i, wb_sel_i);
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stat_q <= 32'h0;
        end else begin
            stat_q <= {14'h0,
                       link.ecrc_generate_enable_out,
                       link.ecrc_check_enable_out,
                       1'b0, link.traffic_class_map_out,
                       5'h00, link.link_power_state_code};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0;
        end else begin
            ack_q <= req;
            if (req && !wb_we_i) begin
                case (wb_adr_i)
                    WB_IDS_ADDR:    dat_q <= ids_q;
                    WB_SUBSYS_ADDR: dat_q <= sub_q;
                    WB_MISC_ADDR:   dat_q <= misc_q;
                    WB_SN_LO_ADDR:  dat_q <= sn_lo_q;
                    WB_SN_HI_ADDR:  dat_q <= sn_hi_q;
                    WB_STAT_ADDR:   dat_q <= stat_q;
                    default:        dat_q <= 32'h0;
                endcase
            end
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;

    //--------------------------------------------------------
    // drive the link straight from the registers
    //--------------------------------------------------------
    assign link.device_identifier_in           = ids_q[31:16];
    assign link.vendor_identifier_in           = ids_q[15:0];
    assign link.subsystem_identifier_in        = sub_q[31:16];
    assign link.subsystem_vendor_identifier_in = sub_q[15:0];
    assign link.revision_identifier_in         = misc_q[7:0];
    assign link.interrupt_message_number_in    =
        misc_q[MISC_MSG_LSB +: 5];
    assign link.common_clock_override  = misc_q[MISC_CC_BIT];
    assign link.extended_sync_override = misc_q[MISC_ES_BIT];
    assign link.forced_payload_size    = misc_q[MISC_MPS_LSB +: 3];
    assign link.serial_number_in       = {sn_hi_q, sn_lo_q};
endmodule // cil_user
